// ==== hdl/expander_device.sv ====
/*
 Sixteen-bit port expander, slave end of the two-wire link.
 Assumes scl, sda, straps and port pins are asynchronous to sys_clk,
 and scl high and low phases last at least four sys_clk cycles.
*/
`include "expander_cfg.svh"

module expander_device #(
   parameter int PORT_W = 8
) (
   input wire logic sys_clk,
   input wire logic nrst,
   two_wire_if.dev link,
   input wire logic [2*PORT_W-1:0] port_pin_in,
   output logic [2*PORT_W-1:0] port_pin_out,
   output logic [2*PORT_W-1:0] port_pin_oe_n,
   input wire logic addr_strap_bit0,
   input wire logic addr_strap_bit1,
   input wire logic addr_strap_bit2
);
   import expander_pkg::*;

   logic scl_hi;
   logic sda_hi;
   logic scl_rise;
   logic scl_fall;
   logic sda_rise;
   logic sda_fall;
   logic [2*PORT_W-1:0] pin_lvl;
   logic [2:0] strap_lvl;
   logic [2:0] strap_reg;
   logic [1:0] init_cnt_reg;
   logic init_done;
   logic [PORT_W-1:0] drive_reg [2];
   logic [PORT_W-1:0] inv_reg [2];
   logic [PORT_W-1:0] dir_reg [2];
   logic [PORT_W-1:0] latch_reg [2];
   logic [1:0] port_alert;
   logic alert_oe_n_reg;
   dev_state_t state_reg;
   logic [2:0] bit_cnt_reg;
   byte_t shift_reg;
   logic [2:0] ptr_reg;
   logic rd_mode_reg;
   logic ack_phase_reg;
   logic master_ack_reg;
   logic sda_oe_n_reg;
   logic start_seen;
   logic stop_seen;
   byte_t rx_byte;
   logic byte_end;
   logic wr_en;
   logic rd_load;
   byte_t rd_val;

   line_sampler #(.WIDTH(2), .RST_VAL(2'h3)) u_link_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .raw_in({link.scl, link.sda}),
      .level({scl_hi, sda_hi}),
      .rise({scl_rise, sda_rise}),
      .fall({scl_fall, sda_fall})
   );

   line_sampler #(.WIDTH(2*PORT_W + 3)) u_pin_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .raw_in({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0, port_pin_in}),
      .level({strap_lvl, pin_lvl}),
      .rise(),
      .fall()
   );

   assign start_seen = sda_fall && scl_hi;
   assign stop_seen = sda_rise && scl_hi;
   assign rx_byte = {shift_reg[6:0], sda_hi};
   assign byte_end = scl_rise && (bit_cnt_reg == `EXP_LAST_BIT);
   assign init_done = (init_cnt_reg == `EXP_INIT_CYC);
   assign wr_en = !start_seen && !stop_seen && (state_reg == S_WDATA) && byte_end;
   assign rd_load = !start_seen && !stop_seen && scl_fall && ack_phase_reg
      && (((state_reg == S_AACK) && rd_mode_reg) || ((state_reg == S_RACK) && master_ack_reg));

   // Straps and input latches are caught once the synchronisers have filled
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         init_cnt_reg <= '0;
         strap_reg <= '0;
      end
      else if (!init_done)
      begin
         init_cnt_reg <= init_cnt_reg + 2'h1;
         strap_reg <= strap_lvl;
      end
   end

   always_comb
   begin
      unique case (ptr_reg)
         `EXP_REG_IN0: rd_val = pin_lvl[0 +: PORT_W] ^ inv_reg[0];
         `EXP_REG_IN1: rd_val = pin_lvl[PORT_W +: PORT_W] ^ inv_reg[1];
         `EXP_REG_DRV0: rd_val = drive_reg[0];
         `EXP_REG_DRV1: rd_val = drive_reg[1];
         `EXP_REG_INV0: rd_val = inv_reg[0];
         `EXP_REG_INV1: rd_val = inv_reg[1];
         `EXP_REG_DIR0: rd_val = dir_reg[0];
         `EXP_REG_DIR1: rd_val = dir_reg[1];
      endcase
   end

   // Register writes; input pointers fall through and are dropped
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         drive_reg <= '{`EXP_DRIVE_RST, `EXP_DRIVE_RST};
         inv_reg <= '{`EXP_INV_RST, `EXP_INV_RST};
         dir_reg <= '{`EXP_DIR_RST, `EXP_DIR_RST};
      end
      else if (wr_en)
      begin
         unique case (ptr_reg)
            `EXP_REG_DRV0: drive_reg[0] <= rx_byte;
            `EXP_REG_DRV1: drive_reg[1] <= rx_byte;
            `EXP_REG_INV0: inv_reg[0] <= rx_byte;
            `EXP_REG_INV1: inv_reg[1] <= rx_byte;
            `EXP_REG_DIR0: dir_reg[0] <= rx_byte;
            `EXP_REG_DIR1: dir_reg[1] <= rx_byte;
            `EXP_REG_IN0, `EXP_REG_IN1: ;
         endcase
      end
   end

   // Input latches: reloaded at start-up and when that port is read
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         latch_reg <= '{'0, '0};
      end
      else if (!init_done)
      begin
         latch_reg[0] <= pin_lvl[0 +: PORT_W];
         latch_reg[1] <= pin_lvl[PORT_W +: PORT_W];
      end
      else if (rd_load && (ptr_reg == `EXP_REG_IN0))
      begin
         latch_reg[0] <= pin_lvl[0 +: PORT_W];
      end
      else if (rd_load && (ptr_reg == `EXP_REG_IN1))
      begin
         latch_reg[1] <= pin_lvl[PORT_W +: PORT_W];
      end
   end

   // Mismatch on input-direction pins only; a fresh input may mismatch
   assign port_alert[0] = |((pin_lvl[0 +: PORT_W] ^ latch_reg[0]) & dir_reg[0]);
   assign port_alert[1] = |((pin_lvl[PORT_W +: PORT_W] ^ latch_reg[1]) & dir_reg[1]);

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         alert_oe_n_reg <= 1'b1;
      end
      else
      begin
         alert_oe_n_reg <= !(init_done && (|port_alert));
      end
   end

   // Slave transfer sequencer; moves follow scl edges of the master, START and STOP follow sda edges with scl high
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg <= S_IDLE;
         bit_cnt_reg <= '0;
         shift_reg <= '0;
         ptr_reg <= `EXP_REG_IN0;
         rd_mode_reg <= 1'b0;
         ack_phase_reg <= 1'b0;
         master_ack_reg <= 1'b0;
         sda_oe_n_reg <= 1'b1;
      end
      else if (start_seen)
      begin
         state_reg <= S_ADDR;
         bit_cnt_reg <= '0;
         ack_phase_reg <= 1'b0;
         sda_oe_n_reg <= 1'b1;
      end
      else if (stop_seen)
      begin
         state_reg <= S_IDLE;
         sda_oe_n_reg <= 1'b1;
      end
      else if (rd_load)
      begin
         state_reg <= S_RDATA;
         shift_reg <= rd_val;
         sda_oe_n_reg <= rd_val[7];
         ptr_reg <= ptr_reg ^ 3'h1;
         bit_cnt_reg <= '0;
         ack_phase_reg <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            S_IDLE: ;
            S_ADDR, S_CMD, S_WDATA:
            begin
               if (scl_rise)
               begin
                  shift_reg <= rx_byte;
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
               end
               if (byte_end && (state_reg == S_ADDR))
               begin
                  if ((rx_byte[7:4] == `EXP_FIXED_ADDR) && (rx_byte[3:1] == strap_reg))
                  begin
                     state_reg <= S_AACK;
                     rd_mode_reg <= (rx_byte[0] == `EXP_DIR_READ);
                  end
                  else
                  begin
                     state_reg <= S_IDLE;
                  end
               end
               else if (byte_end && (state_reg == S_CMD))
               begin
                  state_reg <= S_CACK;
                  ptr_reg <= rx_byte[2:0];
               end
               else if (byte_end)
               begin
                  state_reg <= S_WACK;
                  ptr_reg <= ptr_reg ^ 3'h1;
               end
            end
            S_AACK, S_CACK, S_WACK:
            begin
               if (scl_fall && !ack_phase_reg)
               begin
                  sda_oe_n_reg <= 1'b0;
                  ack_phase_reg <= 1'b1;
               end
               else if (scl_fall)
               begin
                  sda_oe_n_reg <= 1'b1;
                  ack_phase_reg <= 1'b0;
                  bit_cnt_reg <= '0;
                  state_reg <= (state_reg == S_AACK) ? S_CMD : S_WDATA;
               end
            end
            S_RDATA:
            begin
               if (byte_end)
               begin
                  state_reg <= S_RACK;
               end
               else if (scl_rise)
               begin
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
               end
               else if (scl_fall)
               begin
                  shift_reg <= {shift_reg[6:0], 1'b0};
                  sda_oe_n_reg <= shift_reg[6];
               end
            end
            S_RACK:
            begin
               if (scl_fall && !ack_phase_reg)
               begin
                  sda_oe_n_reg <= 1'b1;
                  ack_phase_reg <= 1'b1;
               end
               else if (scl_rise)
               begin
                  master_ack_reg <= !sda_hi;
               end
               else if (scl_fall)
               begin
                  state_reg <= S_IDLE;
               end
            end
         endcase
      end
   end

   assign link.sda_d_o = 1'b0;
   assign link.sda_d_oe_n = sda_oe_n_reg;
   assign link.alert_d_o = 1'b0;
   assign link.alert_d_oe_n = alert_oe_n_reg;
   assign port_pin_out = {drive_reg[1], drive_reg[0]};
   assign port_pin_oe_n = {dir_reg[1], dir_reg[0]};
endmodule : expander_device

// ==== hdl/expander_master.sv ====
/*
 Two-wire master end: one register write or one register read per request.
 Assumes the expander end answers on the same link; scl is divided from sys_clk.
*/
`include "expander_cfg.svh"

module expander_master #(
   parameter int QUARTER_CYC = `EXP_QUARTER_CYC
) (
   input wire logic sys_clk,
   input wire logic nrst,
   two_wire_if.mstr link,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_read,
   input wire logic [2:0] req_target,
   input wire expander_pkg::byte_t req_cmd,
   input wire expander_pkg::byte_t req_wdata,
   output logic done_pulse,
   output expander_pkg::byte_t rsp_data,
   output logic rsp_nack,
   output logic alert_seen
);
   import expander_pkg::*;

   mstr_phase_t phase_reg;
   logic [15:0] quarter_cnt_reg;
   logic tick;
   logic [1:0] q_reg;
   logic [1:0] byte_idx_reg;
   logic [3:0] bit_idx_reg;
   logic read_reg;
   logic [2:0] target_reg;
   byte_t cmd_reg;
   byte_t wdata_reg;
   byte_t rx_reg;
   logic nack_reg;
   logic scl_oe_n_reg;
   logic sda_oe_n_reg;
   logic done_reg;
   byte_t rsp_data_reg;
   logic rsp_nack_reg;
   logic sda_hi;
   logic alert_hi;
   byte_t tx_byte;
   logic last_byte;

   line_sampler #(.WIDTH(2), .RST_VAL(2'h3)) u_line_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .raw_in({link.sda, link.alert_n}),
      .level({sda_hi, alert_hi}),
      .rise(),
      .fall()
   );

   assign tick = (quarter_cnt_reg == 16'(QUARTER_CYC - 1));
   assign last_byte = (byte_idx_reg == (read_reg ? `EXP_LAST_RD_BYTE : `EXP_LAST_WR_BYTE));

   always_comb
   begin
      unique case (byte_idx_reg)
         2'h0: tx_byte = {`EXP_FIXED_ADDR, target_reg, `EXP_DIR_WRITE};
         2'h1: tx_byte = cmd_reg;
         2'h2: tx_byte = read_reg ? {`EXP_FIXED_ADDR, target_reg, `EXP_DIR_READ} : wdata_reg;
         2'h3: tx_byte = 8'hFF;
      endcase
   end

   // Quarter-period timer, idle outside a transfer
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         quarter_cnt_reg <= '0;
         q_reg <= '0;
      end
      else if (phase_reg == P_IDLE || tick)
      begin
         quarter_cnt_reg <= '0;
         q_reg <= (phase_reg == P_IDLE) ? 2'h0 : q_reg + 2'h1;
      end
      else
      begin
         quarter_cnt_reg <= quarter_cnt_reg + 16'h1;
      end
   end

   // Each START and bit is four quarters: set sda, raise scl, act, lower scl; STOP ends with scl left high
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         phase_reg <= P_IDLE;
         byte_idx_reg <= '0;
         bit_idx_reg <= '0;
         read_reg <= 1'b0;
         target_reg <= '0;
         cmd_reg <= '0;
         wdata_reg <= '0;
         rx_reg <= '0;
         nack_reg <= 1'b0;
         scl_oe_n_reg <= 1'b1;
         sda_oe_n_reg <= 1'b1;
         done_reg <= 1'b0;
         rsp_data_reg <= '0;
         rsp_nack_reg <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         unique case (phase_reg)
            P_IDLE:
            begin
               if (req_valid)
               begin
                  phase_reg <= P_START;
                  read_reg <= req_read;
                  target_reg <= req_target;
                  cmd_reg <= req_cmd;
                  wdata_reg <= req_wdata;
                  byte_idx_reg <= '0;
                  nack_reg <= 1'b0;
               end
            end
            P_START:
            begin
               if (tick)
               begin
                  unique case (q_reg)
                     2'h0: sda_oe_n_reg <= 1'b1;
                     2'h1: scl_oe_n_reg <= 1'b1;
                     2'h2: sda_oe_n_reg <= 1'b0;
                     2'h3:
                     begin
                        scl_oe_n_reg <= 1'b0;
                        bit_idx_reg <= '0;
                        phase_reg <= P_BITS;
                     end
                  endcase
               end
            end
            P_BITS:
            begin
               if (tick)
               begin
                  unique case (q_reg)
                     2'h0: sda_oe_n_reg <= (bit_idx_reg == `EXP_ACK_BIT) ? 1'b1 : tx_byte[3'(`EXP_LAST_BIT - bit_idx_reg)];
                     2'h1: scl_oe_n_reg <= 1'b1;
                     2'h2:
                     begin
                        if (bit_idx_reg != `EXP_ACK_BIT)
                        begin
                           rx_reg <= {rx_reg[6:0], sda_hi};
                        end
                        else if (byte_idx_reg != `EXP_LAST_RD_BYTE || !read_reg)
                        begin
                           nack_reg <= sda_hi;
                        end
                     end
                     2'h3:
                     begin
                        scl_oe_n_reg <= 1'b0;
                        bit_idx_reg <= bit_idx_reg + 4'h1;
                        if (bit_idx_reg == `EXP_ACK_BIT)
                        begin
                           bit_idx_reg <= '0;
                           byte_idx_reg <= byte_idx_reg + 2'h1;
                           if (nack_reg || last_byte)
                           begin
                              phase_reg <= P_STOP;
                           end
                           else if (read_reg && byte_idx_reg == `EXP_RSTART_BYTE)
                           begin
                              phase_reg <= P_START;
                           end
                        end
                     end
                  endcase
               end
            end
            P_STOP:
            begin
               if (tick)
               begin
                  unique case (q_reg)
                     2'h0: sda_oe_n_reg <= 1'b0;
                     2'h1: scl_oe_n_reg <= 1'b1;
                     2'h2: sda_oe_n_reg <= 1'b1;
                     2'h3:
                     begin
                        phase_reg <= P_IDLE;
                        done_reg <= 1'b1;
                        rsp_data_reg <= rx_reg;
                        rsp_nack_reg <= nack_reg;
                     end
                  endcase
               end
            end
         endcase
      end
   end

   assign req_ready = (phase_reg == P_IDLE);
   assign done_pulse = done_reg;
   assign rsp_data = rsp_data_reg;
   assign rsp_nack = rsp_nack_reg;
   assign alert_seen = !alert_hi;
   assign link.scl_m_o = 1'b0;
   assign link.scl_m_oe_n = scl_oe_n_reg;
   assign link.sda_m_o = 1'b0;
   assign link.sda_m_oe_n = sda_oe_n_reg;
endmodule : expander_master

// ==== hdl/line_sampler.sv ====
/*
 Two-flop synchroniser with edge detection for asynchronous lines.
 Assumes the raw inputs come from outside the sys_clk domain.
*/
module line_sampler #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] raw_in,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] prev_reg;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
         prev_reg <= RST_VAL;
      end
      else
      begin
         meta_reg <= raw_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign level = sync_reg;
   assign rise = sync_reg & ~prev_reg;
   assign fall = ~sync_reg & prev_reg;
endmodule : line_sampler

// ==== shared/expander_cfg.svh ====
/*
 Constants of the two-wire port expander: slave address pattern,
 register pointers, reset values and bus timing.
 Assumes inclusion by both ends and by the package.
*/
`ifndef EXPANDER_CFG_SVH
`define EXPANDER_CFG_SVH

`define EXP_FIXED_ADDR 4'h4
`define EXP_DIR_READ 1'b1
`define EXP_DIR_WRITE 1'b0
`define EXP_REG_IN0 3'h0
`define EXP_REG_IN1 3'h1
`define EXP_REG_DRV0 3'h2
`define EXP_REG_DRV1 3'h3
`define EXP_REG_INV0 3'h4
`define EXP_REG_INV1 3'h5
`define EXP_REG_DIR0 3'h6
`define EXP_REG_DIR1 3'h7
`define EXP_DRIVE_RST 8'hFF
`define EXP_INV_RST 8'h00
`define EXP_DIR_RST 8'hFF
`define EXP_LAST_BIT 4'h7
`define EXP_ACK_BIT 4'h8
`define EXP_INIT_CYC 2'h3
`define EXP_LAST_WR_BYTE 2'h2
`define EXP_LAST_RD_BYTE 2'h3
`define EXP_RSTART_BYTE 2'h1
`define EXP_SYS_CLK_NS 100
`define EXP_SCL_PERIOD_NS 10000
`define EXP_QUARTER_CYC ((`EXP_SCL_PERIOD_NS + 4 * `EXP_SYS_CLK_NS - 1) / (4 * `EXP_SYS_CLK_NS))

`endif

// ==== shared/expander_pkg.sv ====
/*
 Types shared by both ends of the two-wire port expander link.
 Assumes expander_cfg.svh sits on the include path.
*/
package expander_pkg;
   `include "expander_cfg.svh"

   typedef logic [7:0] byte_t;

   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_AACK, S_CMD, S_CACK, S_WDATA, S_WACK, S_RDATA, S_RACK
   } dev_state_t;

   typedef enum logic [1:0] {
      P_IDLE, P_START, P_BITS, P_STOP
   } mstr_phase_t;
endpackage : expander_pkg

// ==== shared/two_wire_if.sv ====
/*
 Two-wire link between the master end and the expander end.
 Open-drain lines resolve here with an implied pull-up; enables are low while driving.
*/
interface two_wire_if;
   logic scl_m_o;
   logic scl_m_oe_n;
   logic sda_m_o;
   logic sda_m_oe_n;
   logic sda_d_o;
   logic sda_d_oe_n;
   logic alert_d_o;
   logic alert_d_oe_n;
   logic scl;
   logic sda;
   logic alert_n;

   assign scl = !(!scl_m_oe_n && !scl_m_o);
   assign sda = !((!sda_m_oe_n && !sda_m_o) || (!sda_d_oe_n && !sda_d_o));
   assign alert_n = !(!alert_d_oe_n && !alert_d_o);

   modport dev (input scl, input sda, output sda_d_o, output sda_d_oe_n, output alert_d_o, output alert_d_oe_n);
   modport mstr (input scl, input sda, input alert_n, output scl_m_o, output scl_m_oe_n, output sda_m_o,
      output sda_m_oe_n);
endinterface : two_wire_if

// ==== test/expander_props.sv ====
/* Assertions on the two-wire link between master and expander ends.
   Assumes instantiation beside two_wire_if, one sys_clk domain. */
module expander_props #(
   parameter logic [2:0] STRAP = 3'h5
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_m_oe_n,
   input wire logic sda_d_oe_n,
   input wire logic alert_d_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic scl_reg;
   logic sda_reg;
   logic busy_reg;
   logic addr_reg;
   logic rd_reg;
   logic [3:0] pos_reg;
   logic [3:0] idle_reg;
   logic [7:0] sh_reg;
   wire logic rise = scl && !scl_reg;
   wire logic start = scl && scl_reg && sda_reg && !sda;
   wire logic stop = scl && scl_reg && !sda_reg && sda;

   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst)
      begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end
      else
      begin
         scl_reg <= scl;
         sda_reg <= sda;
      end

   // Bit position, address byte and direction of the current transfer
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst)
      begin
         busy_reg <= 1'b0;
         addr_reg <= 1'b0;
         rd_reg <= 1'b0;
         pos_reg <= 4'h0;
         sh_reg <= 8'h00;
      end
      else if (start)
      begin
         busy_reg <= 1'b1;
         addr_reg <= 1'b1;
         rd_reg <= 1'b0;
         pos_reg <= 4'h0;
      end
      else if (stop)
         busy_reg <= 1'b0;
      else if (rise)
      begin
         sh_reg <= {sh_reg[6:0], sda};
         pos_reg <= (pos_reg == 4'h8) ? 4'h0 : pos_reg + 4'h1;
         if (pos_reg == 4'h8)
         begin
            addr_reg <= 1'b0;
            rd_reg <= rd_reg | (addr_reg & sh_reg[0]);
         end
      end

   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst)
         idle_reg <= 4'h0;
      else if (busy_reg)
         idle_reg <= 4'h0;
      else if (idle_reg != 4'h8)
         idle_reg <= idle_reg + 4'h1;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   property p_hold_high; scl && scl_reg |-> $stable(sda_d_oe_n); endproperty
   a_hold_high: assert property (p_hold_high) else $error("device moved sda with scl high");
   property p_quiet_boot; !$past(nrst) |-> (sda_d_oe_n && alert_d_oe_n) [*3]; endproperty
   a_quiet_boot: assert property (p_quiet_boot) else $error("device active after reset");
   property p_idle_quiet; idle_reg == 4'h8 |-> sda_d_oe_n; endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("device drove idle bus");
   property p_stop_free; stop |-> sda_d_oe_n [*4]; endproperty
   a_stop_free: assert property (p_stop_free) else $error("device drove after stop");
   property p_addr_ack;
      rise && addr_reg && pos_reg == 4'h8 |-> !sda == (sh_reg[7:1] == {4'h4, STRAP});
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
   property p_slot; rise && !sda_d_oe_n |-> (pos_reg == 4'h8) != rd_reg; endproperty
   a_slot: assert property (p_slot) else $error("device drove outside its slot");
   property p_start_clk; scl && scl_reg && $fell(sda_m_oe_n) |-> ##[1:40] !scl; endproperty
   a_start_clk: assert property (p_start_clk) else $error("start not followed by clock");
   property p_stop_idle; stop |-> (scl && sda) [*8]; endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
endmodule : expander_props

// ==== test/i2c_sixteen_bit_io_expander_tb.sv ====
/* Testbench: master end drives register traffic into the expander end.
   Assumes the shared package, interface and both design ends compiled first. */
module i2c_sixteen_bit_io_expander_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import expander_pkg::*;
   localparam logic [2:0] STRAP = 3'h5;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   logic req_read = 1'b0;
   logic [2:0] req_target = STRAP;
   byte_t req_cmd = 8'h00;
   byte_t req_wdata = 8'h00;
   logic req_ready;
   logic done_pulse;
   byte_t rsp_data;
   logic rsp_nack;
   logic alert_seen;
   logic [15:0] ext_pins = 16'hA53C;
   logic [15:0] pin_out;
   logic [15:0] pin_oe_n;
   wire logic [15:0] pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_pins);
   byte_t rst_tab [8] = '{8'h3C, 8'hA5, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF};
   int fails = 0;
   int samples_checked = 0;

   always #50 sys_clk = ~sys_clk;

   two_wire_if link ();
   expander_device u_expander_device (.sys_clk(sys_clk), .nrst(nrst), .link(link), .port_pin_in(pin_in),
      .port_pin_out(pin_out), .port_pin_oe_n(pin_oe_n), .addr_strap_bit0(STRAP[0]),
      .addr_strap_bit1(STRAP[1]), .addr_strap_bit2(STRAP[2]));
   expander_master #(.QUARTER_CYC(8)) u_expander_master (.sys_clk(sys_clk), .nrst(nrst), .link(link),
      .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read), .req_target(req_target),
      .req_cmd(req_cmd), .req_wdata(req_wdata), .done_pulse(done_pulse), .rsp_data(rsp_data),
      .rsp_nack(rsp_nack), .alert_seen(alert_seen));
   expander_props #(.STRAP(STRAP)) u_expander_props (.sys_clk(sys_clk), .nrst(nrst), .scl(link.scl),
      .sda(link.sda), .sda_m_oe_n(link.sda_m_oe_n), .sda_d_oe_n(link.sda_d_oe_n),
      .alert_d_oe_n(link.alert_d_oe_n));

   task automatic give_verdict;
      if (fails == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict

   task automatic chk8(input byte_t g, input byte_t e);
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %0t byte %h want %h", $time, g, e);
      end
   endtask : chk8

   task automatic chk1(input logic g, input logic e);
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %0t flag %b want %b", $time, g, e);
      end
   endtask : chk1

   task automatic xfer(input logic r, input logic [2:0] t, input byte_t c, input byte_t d);
      @(negedge sys_clk);
      chk1(req_ready, 1'b1);
      req_read = r;
      req_target = t;
      req_cmd = c;
      req_wdata = d;
      req_valid = 1'b1;
      @(negedge sys_clk);
      req_valid = 1'b0;
      chk1(req_ready, 1'b0);
      for (int i = 0; i < 2000 && done_pulse !== 1'b1; i++)
         @(negedge sys_clk);
      chk1(done_pulse, 1'b1);
   endtask : xfer

   task automatic wr(input byte_t c, input byte_t d);
      xfer(1'b0, STRAP, c, d);
   endtask : wr

   task automatic rd(input byte_t c, input byte_t e);
      xfer(1'b1, STRAP, c, 8'h00);
      chk8(rsp_data, e);
   endtask : rd

   task automatic alert_is(input logic e);
      repeat (12) @(negedge sys_clk);
      chk1(alert_seen, e);
   endtask : alert_is

   initial
   begin
      repeat (60000) @(posedge sys_clk);
      fails++;
      $display("[ERR] %0t run hung", $time);
      give_verdict();
   end

   initial
   begin
      repeat (20) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (8) @(negedge sys_clk);
      for (int r = 0; r < 8; r++)
         rd(r[7:0], rst_tab[r]);
      alert_is(1'b0);
      wr(8'h04, 8'h0F);
      rd(8'h00, 8'h33);
      wr(8'h04, 8'h00);
      wr(8'h02, 8'h5A);
      wr(8'h06, 8'hF0);
      chk8(pin_oe_n[7:0], 8'hF0);
      chk8(pin_out[7:0], 8'h5A);
      alert_is(1'b0);
      rd(8'h02, 8'h5A);
      rd(8'h00, 8'h3A);
      wr(8'h06, 8'hFF);
      alert_is(1'b1);
      rd(8'h00, 8'h3C);
      alert_is(1'b0);
      ext_pins[15:8] = 8'hA4;
      alert_is(1'b1);
      rd(8'h00, 8'h3C);
      alert_is(1'b1);
      rd(8'h01, 8'hA4);
      alert_is(1'b0);
      ext_pins[0] = 1'b1;
      alert_is(1'b1);
      ext_pins[0] = 1'b0;
      alert_is(1'b0);
      wr(8'h00, 8'h55);
      rd(8'h00, 8'h3C);
      for (int i = 0; i < 3; i++)
      begin
         xfer(1'b0, STRAP ^ (3'h1 << i), 8'h02, 8'h00);
         chk1(rsp_nack, 1'b1);
      end
      rd(8'h02, 8'h5A);
      chk1(rsp_nack, 1'b0);
      wr(8'h03, 8'hC3);
      wr(8'h07, 8'h00);
      chk8(pin_oe_n[15:8], 8'h00);
      chk8(pin_out[15:8], 8'hC3);
      rd(8'h01, 8'hC3);
      wr(8'h05, 8'hFF);
      rd(8'h01, 8'h3C);
      give_verdict();
   end
endmodule : i2c_sixteen_bit_io_expander_tb
